// ==== hdl/test_hooks_pkg.sv ====
// constants shared by the cache and tlb test hook block
package test_hooks_pkg;
    // test register selects carried by the register-move port
    localparam logic [2:0] SEL_CACHE_DATA  = 3'h3;
    localparam logic [2:0] SEL_CACHE_STAT  = 3'h4;
    localparam logic [2:0] SEL_CACHE_CTRL  = 3'h5;
    localparam logic [2:0] SEL_TLB_CMD     = 3'h6;
    localparam logic [2:0] SEL_TLB_DATA    = 3'h7;
    // cache control test register fields
    localparam int         CTRL_CODE_LSB   = 0;
    localparam int         CTRL_ENTRY_LSB  = 2;
    localparam int         CTRL_SET_LSB    = 4;
    localparam int         CACHE_SET_W     = 7;
    localparam logic [1:0] CODE_BUFFER     = 2'h0;
    localparam logic [1:0] CODE_WRITE      = 2'h1;
    localparam logic [1:0] CODE_READ       = 2'h2;
    localparam logic [1:0] CODE_FLUSH      = 2'h3;
    // cache status test register fields
    localparam int         STAT_TAG_LSB    = 11;
    localparam int         STAT_VALID_BIT  = 10;
    localparam int         STAT_LRU_LSB    = 7;
    localparam int         STAT_SETV_LSB   = 3;
    localparam int         CACHE_TAG_W     = 21;
    // tlb command test register fields
    localparam int         CMD_LIN_LSB     = 12;
    localparam int         CMD_TAG_LSB     = 15;
    localparam int         CMD_V_BIT       = 11;
    localparam int         CMD_D_BIT       = 10;
    localparam int         CMD_DN_BIT      = 9;
    localparam int         CMD_U_BIT       = 8;
    localparam int         CMD_UN_BIT      = 7;
    localparam int         CMD_W_BIT       = 6;
    localparam int         CMD_WN_BIT      = 5;
    localparam int         CMD_OP_BIT      = 0;
    // tlb data test register fields
    localparam int         DATA_PHYS_LSB   = 10;
    localparam int         DATA_LRU_LSB    = 7;
    localparam int         DATA_HIT_BIT    = 4;
    localparam int         DATA_WAY_LSB    = 2;
    // tlb geometry
    localparam int         TLB_WAYS        = 4;
    localparam int         TLB_SETS        = 8;
    localparam int         TLB_DATA_W      = 22;
    localparam int         TLB_LTAG_W      = 17;
    localparam int         TLB_TAG_W       = 21;
    // stored tag layout: linear tag above valid, dirty, user, write
    localparam int         TAG_V_BIT       = 3;
    localparam int         TAG_D_BIT       = 2;
    localparam int         TAG_U_BIT       = 1;
    localparam int         TAG_W_BIT       = 0;
    localparam logic [31:0] REG_RESET      = 32'h0000_0000;
endpackage

// ==== hdl/plru_tree.sv ====
// three-bit pseudo-lru victim choice and most-recent update
module plru_tree (
    // current set state
    input  wire logic [2:0] lru_in,
    input  wire logic [1:0] way_in,
    // results
    output logic      [1:0] victim_out,
    output logic      [2:0] lru_out
);
    // bit 0 picks the pair, bit 1 ways 0/1, bit 2 ways 2/3
    always_comb
    begin
        victim_out = lru_in[0] ? {1'b1, lru_in[2]} : {1'b0, lru_in[1]};
        lru_out    = lru_in;
        unique case (way_in)
            2'h0:
            begin
                lru_out[0] = 1'b1;
                lru_out[1] = 1'b1;
            end
            2'h1:
            begin
                lru_out[0] = 1'b1;
                lru_out[1] = 1'b0;
            end
            2'h2:
            begin
                lru_out[0] = 1'b0;
                lru_out[2] = 1'b1;
            end
            2'h3:
            begin
                lru_out[0] = 1'b0;
                lru_out[2] = 1'b0;
            end
        endcase
    end
endmodule // plru_tree

// ==== hdl/tlb_way_match.sv ====
// compare one tlb way against a lookup with forced protection matches
module tlb_way_match (
    // stored entry
    input  wire logic [20:0] tag_in,
    // lookup command
    input  wire logic [16:0] ltag_in,
    input  wire logic        valid_in,
    input  wire logic [5:0]  pairs_in,
    // result
    output logic             hit_out
);
    function automatic logic pair_ok(input logic [1:0] code, input logic stored);
        unique case (code)
            2'h0:    pair_ok = 1'b0;
            2'h1:    pair_ok = !stored;
            2'h2:    pair_ok = stored;
            default: pair_ok = 1'b1;
        endcase
    endfunction

    always_comb
    begin
        hit_out = (tag_in[20:4] == ltag_in)
                  && (tag_in[test_hooks_pkg::TAG_V_BIT] == valid_in)
                  && pair_ok(pairs_in[5:4], tag_in[test_hooks_pkg::TAG_D_BIT])
                  && pair_ok(pairs_in[3:2], tag_in[test_hooks_pkg::TAG_U_BIT])
                  && pair_ok(pairs_in[1:0], tag_in[test_hooks_pkg::TAG_W_BIT]);
    end
endmodule // tlb_way_match

// ==== hdl/cache_tlb_test_hooks.sv ====
// cache read-back, cache flush and tlb write/lookup test registers
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - control code 10 reads the selected set and entry into the read buffer.
// - that read loads status with entry tag, valid, set lru and set valids.
// - that read fills the read buffer with the 128-bit data line.
// - with code 00, a data register read returns the entry-selected buffer word.
// - code 11 flushes: lru and valids cleared, tags and data kept.
// - a test-register flush runs no external flush bus cycle.
// - tlb is 4-way, 32 entries, eight sets.
// - tlb data entry is 20-bit physical page plus two page attributes.
// - tlb tag entry is 17-bit linear tag plus four protection bits.
// - one three-bit pseudo-lru state per tlb set, same as cache.
// - each command register write starts one tlb write or lookup.
// - command holds linear address 31:12, protection 11:5, operation bit 0.
// - low three linear bits pick the set, upper 17 form the tag.
// - operation bit 0 means write, 1 means lookup.
// - data register holds physical 31:12, attributes 11:10, lru 9:7, way 3:2.
// - on write, data bit 4 picks way: 0 pseudo-lru, 1 bits 3:2.
// - lookup sets data bit 4 to hit; hit reports page, attributes, lru, way.
// - writes and lookup hits make the touched entry most recently used.
// - on write, pair 01 stores 0 and pair 10 stores 1.
// - on lookup, pairs 00 miss, 01 match 0, 10 match 1, 11 any.
// - the data register lru field is ignored by test writes.
// - reported lru is the state before this lookup's update.
module cache_tlb_test_hooks (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // register-move port
    input  wire logic         reg_wr_in,
    input  wire logic         reg_rd_in,
    input  wire logic [2:0]   reg_sel_in,
    input  wire logic [31:0]  reg_wdata_in,
    output logic      [31:0]  reg_rdata_out,
    output logic              reg_rvalid_out,
    // cache array read and flush
    output logic              cache_rd_out,
    output logic      [6:0]   cache_set_out,
    output logic      [1:0]   cache_entry_out,
    output logic              cache_flush_out,
    input  wire logic [127:0] cache_data_in,
    input  wire logic [20:0]  cache_tag_in,
    input  wire logic         cache_valid_in,
    input  wire logic [2:0]   cache_set_lru_in,
    input  wire logic [3:0]   cache_set_valid_in
);
    localparam int WAYS = test_hooks_pkg::TLB_WAYS;
    localparam int SETS = test_hooks_pkg::TLB_SETS;

    // the tree and the two-bit way fields only serve four ways of eight sets
    if (WAYS != 4 || SETS != 8)
    begin : g_geom_check
        $error("tlb geometry not supported");
    end

    typedef struct packed {
        logic [31:0]                                        ctrl;
        logic [31:0]                                        stat;
        logic [127:0]                                       rbuf;
        logic [31:0]                                        cmd;
        logic [31:0]                                        data;
        logic [WAYS-1:0][SETS-1:0][test_hooks_pkg::TLB_DATA_W-1:0] tdata;
        logic [WAYS-1:0][SETS-1:0][test_hooks_pkg::TLB_TAG_W-1:0]  ttag;
        logic [SETS-1:0][2:0]                               lru;
        logic                                               rd_pend;
        logic                                               flush;
        logic [31:0]                                        rdata;
        logic                                               rvalid;
    } state_t;

    state_t s_q;
    state_t s_d;

    ////////////////////////////////////////////////////////////////////////////
    // decode of the word being written
    logic        ctrl_wr;
    logic        cmd_wr;
    logic        data_rd;
    logic [1:0]  code;
    logic [2:0]  set_idx;
    logic [16:0] ltag;
    logic        op_lookup;
    logic [5:0]  pairs;
    logic [20:0] wr_tag;

    always_comb
    begin
        ctrl_wr   = reg_wr_in && (reg_sel_in == test_hooks_pkg::SEL_CACHE_CTRL);
        cmd_wr    = reg_wr_in && (reg_sel_in == test_hooks_pkg::SEL_TLB_CMD);
        data_rd   = reg_rd_in && (reg_sel_in == test_hooks_pkg::SEL_CACHE_DATA);
        code      = reg_wdata_in[test_hooks_pkg::CTRL_CODE_LSB +: 2];
        set_idx   = reg_wdata_in[test_hooks_pkg::CMD_LIN_LSB +: 3];
        ltag      = reg_wdata_in[test_hooks_pkg::CMD_TAG_LSB +: 17];
        op_lookup = reg_wdata_in[test_hooks_pkg::CMD_OP_BIT];
        pairs     = reg_wdata_in[test_hooks_pkg::CMD_WN_BIT +: 6];
        // write stores the B half of each pair: 01 gives 0, 10 gives 1
        wr_tag    = {ltag,
                     reg_wdata_in[test_hooks_pkg::CMD_V_BIT],
                     reg_wdata_in[test_hooks_pkg::CMD_D_BIT],
                     reg_wdata_in[test_hooks_pkg::CMD_U_BIT],
                     reg_wdata_in[test_hooks_pkg::CMD_W_BIT]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // tlb way compare and replacement
    logic [WAYS-1:0] way_hit;
    logic            hit;
    logic [1:0]      hit_way;
    logic [1:0]      victim;
    logic [1:0]      wr_way;
    logic [1:0]      touch_way;
    logic [2:0]      lru_new;
    logic [2:0]      lru_old;

    for (genvar w = 0; w < WAYS; w++)
    begin : g_way
        tlb_way_match u_match (
            .tag_in   (s_q.ttag[w][set_idx]),
            .ltag_in  (ltag),
            .valid_in (reg_wdata_in[test_hooks_pkg::CMD_V_BIT]),
            .pairs_in (pairs),
            .hit_out  (way_hit[w])
        );
    end

    // a linear address held twice in one set is reported as a miss
    always_comb
    begin
        hit     = ($countones(way_hit) == 1);
        hit_way = 2'h0;
        for (int w = WAYS - 1; w >= 0; w--)
        begin
            if (way_hit[w])
                hit_way = 2'(w);
        end
        lru_old   = s_q.lru[set_idx];
        wr_way    = s_q.data[test_hooks_pkg::DATA_HIT_BIT]
                    ? s_q.data[test_hooks_pkg::DATA_WAY_LSB +: 2] : victim;
        touch_way = op_lookup ? hit_way : wr_way;
    end

    plru_tree u_plru (
        .lru_in     (lru_old),
        .way_in     (touch_way),
        .victim_out (victim),
        .lru_out    (lru_new)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        s_d         = s_q;
        s_d.rd_pend = 1'b0;
        s_d.flush   = 1'b0;
        s_d.rvalid  = 1'b0;
        if (reg_wr_in)
        begin
            unique case (reg_sel_in)
                test_hooks_pkg::SEL_CACHE_STAT: s_d.stat = reg_wdata_in;
                test_hooks_pkg::SEL_TLB_DATA:   s_d.data = reg_wdata_in;
                default: ;
            endcase
        end
        if (ctrl_wr)
        begin
            s_d.ctrl    = reg_wdata_in;
            s_d.rd_pend = (code == test_hooks_pkg::CODE_READ);
            // flush is an internal strobe only; no bus cycle is requested
            s_d.flush   = (code == test_hooks_pkg::CODE_FLUSH);
        end
        // the array answers in the cycle the read strobe is high
        if (s_q.rd_pend)
        begin
            s_d.rbuf = cache_data_in;
            s_d.stat = {cache_tag_in, cache_valid_in, cache_set_lru_in,
                        cache_set_valid_in, 3'h0};
        end
        if (cmd_wr)
        begin
            s_d.cmd = reg_wdata_in;
            if (!op_lookup)
            begin
                // data lru field plays no part here
                s_d.tdata[wr_way][set_idx] =
                    s_q.data[31:test_hooks_pkg::DATA_PHYS_LSB];
                s_d.ttag[wr_way][set_idx]  = wr_tag;
                s_d.lru[set_idx]           = lru_new;
            end
            else
            begin
                s_d.data[test_hooks_pkg::DATA_HIT_BIT] = hit;
                if (hit)
                begin
                    s_d.data[31:test_hooks_pkg::DATA_PHYS_LSB] =
                        s_q.tdata[hit_way][set_idx];
                    s_d.data[test_hooks_pkg::DATA_LRU_LSB +: 3] = lru_old;
                    s_d.data[test_hooks_pkg::DATA_WAY_LSB +: 2] = hit_way;
                    s_d.lru[set_idx] = lru_new;
                end
            end
        end
        if (reg_rd_in)
        begin
            s_d.rvalid = 1'b1;
            unique case (reg_sel_in)
                test_hooks_pkg::SEL_CACHE_DATA:
                    s_d.rdata = (s_q.ctrl[1:0] == test_hooks_pkg::CODE_BUFFER)
                        ? s_q.rbuf[32*s_q.ctrl[test_hooks_pkg::CTRL_ENTRY_LSB +: 2] +: 32]
                        : 32'h0000_0000;
                test_hooks_pkg::SEL_CACHE_STAT: s_d.rdata = s_q.stat;
                test_hooks_pkg::SEL_CACHE_CTRL: s_d.rdata = s_q.ctrl;
                test_hooks_pkg::SEL_TLB_CMD:    s_d.rdata = s_q.cmd;
                test_hooks_pkg::SEL_TLB_DATA:   s_d.rdata = s_q.data;
                default:                        s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    always_comb
    begin
        reg_rdata_out   = s_q.rdata;
        reg_rvalid_out  = s_q.rvalid;
        cache_rd_out    = s_q.rd_pend;
        cache_set_out   = s_q.ctrl[test_hooks_pkg::CTRL_SET_LSB +: 7];
        cache_entry_out = s_q.ctrl[test_hooks_pkg::CTRL_ENTRY_LSB +: 2];
        cache_flush_out = s_q.flush;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    cache_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ctrl_wr && code == test_hooks_pkg::CODE_READ)
        |=> cache_rd_out && !cache_flush_out
            && cache_set_out == $past(reg_wdata_in[10:4]))
        else $error("cache test read not issued");

    status_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
        cache_rd_out |=> s_q.stat[31:11] == $past(cache_tag_in)
            && s_q.stat[6:3] == $past(cache_set_valid_in))
        else $error("status not loaded from cache entry");

    buffer_fill_a: assert property (@(posedge clk_in) disable iff (rst_in)
        cache_rd_out |=> s_q.rbuf == $past(cache_data_in))
        else $error("read buffer not filled");

    word_return_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (data_rd && s_q.ctrl[1:0] == 2'h0 && s_q.ctrl[3:2] == 2'h2)
        |=> reg_rvalid_out && reg_rdata_out == $past(s_q.rbuf[95:64]))
        else $error("wrong read buffer word");

    flush_strobe_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ctrl_wr && code == test_hooks_pkg::CODE_FLUSH)
        |=> cache_flush_out ##1 !cache_flush_out)
        else $error("flush strobe wrong");

    hit_flag_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_wr && op_lookup) |=> s_q.data[4] == $past(hit))
        else $error("lookup hit flag wrong");

    old_lru_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_wr && op_lookup && hit)
        |=> s_q.data[9:7] == $past(lru_old) && s_q.data[3:2] == $past(hit_way))
        else $error("lookup report wrong");

    mru_update_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_wr && (!op_lookup || hit)) |=> s_q.lru[$past(set_idx)] == $past(lru_new))
        else $error("lru not updated");

    forced_way_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_wr && !op_lookup && s_q.data[4])
        |=> s_q.ttag[$past(s_q.data[3:2])][$past(set_idx)] == $past(wr_tag))
        else $error("explicit way not written");

    miss_keeps_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cmd_wr && op_lookup && pairs[5:4] == 2'h0) |=> !s_q.data[4])
        else $error("forced miss reported hit");

    // strobe shape, read answers, tlb replacement, lookup report, command hold and status load
    rd_once_a: assert property (
        cache_rd_out
        |=> !cache_rd_out)
        else $error("read strobe held");

    flush_alone_a: assert property (
        cache_flush_out
        |-> !cache_rd_out)
        else $error("flush and read together");

    read_answer_a: assert property (
        reg_rd_in
        |=> reg_rvalid_out)
        else $error("read not answered");

    read_idle_a: assert property (
        !reg_rd_in
        |=> !reg_rvalid_out)
        else $error("read answer without read");

    word_zero_a: assert property (
        (data_rd && s_q.ctrl[1:0] != test_hooks_pkg::CODE_BUFFER)
        |=> reg_rdata_out == 32'h0000_0000)
        else $error("buffer word outside code 00");

    entry_write_a: assert property (
        (cmd_wr && !op_lookup)
        |=> s_q.tdata[$past(wr_way)][$past(set_idx)] == $past(s_q.data[31:10]))
        else $error("tlb data entry not written");

    lru_victim_a: assert property (
        (cmd_wr && !op_lookup && !s_q.data[4])
        |=> s_q.ttag[$past(victim)][$past(set_idx)] == $past(wr_tag))
        else $error("victim way not written");

    hit_report_a: assert property (
        (cmd_wr && op_lookup && hit)
        |=> s_q.data[31:10] == $past(s_q.tdata[hit_way][set_idx]))
        else $error("hit page not reported");

    miss_lru_a: assert property (
        (cmd_wr && op_lookup && !hit)
        |=> s_q.lru == $past(s_q.lru))
        else $error("lru moved on a miss");

    cmd_store_a: assert property (
        cmd_wr
        |=> s_q.cmd == $past(reg_wdata_in))
        else $error("command register not held");

    status_lru_a: assert property (
        cache_rd_out
        |=> s_q.stat[10:7] == $past({cache_valid_in, cache_set_lru_in}))
        else $error("status valid or lru wrong");
endmodule // cache_tlb_test_hooks

// ==== dv/cache_tlb_test_hooks_tb_top.sv ====
// self-checking bench for the cache read-back, flush and tlb test registers
module cache_tlb_test_hooks_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////////////////
    logic         clk_in;
    logic         rst_in;
    logic         reg_wr_in;
    logic         reg_rd_in;
    logic [2:0]   reg_sel_in;
    logic [31:0]  reg_wdata_in;
    logic [31:0]  reg_rdata_out;
    logic         reg_rvalid_out;
    logic         cache_rd_out;
    logic [6:0]   cache_set_out;
    logic [1:0]   cache_entry_out;
    logic         cache_flush_out;
    logic [127:0] cache_data_in;
    logic [20:0]  cache_tag_in;
    logic         cache_valid_in;
    logic [2:0]   cache_set_lru_in;
    logic [3:0]   cache_set_valid_in;
    int           failures;
    int           cmp_count;
    int           seen;
    logic [31:0]  rdv;
    logic [127:0] line_v;
    // protection pairs d, u, w then expected hit, against an entry storing d=1 u=0 w=1
    localparam logic [6:0] PAIR_CASES [7] = '{7'b10_01_10_1, 7'b01_11_11_0, 7'b11_10_11_0,
        7'b11_11_01_0, 7'b00_11_11_0, 7'b11_11_00_0, 7'b10_01_11_1};
    ////////////////////////////////////////////////////////////////////////////////
    cache_tlb_test_hooks i_cache_tlb_test_hooks (
        .clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_sel_in(reg_sel_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out), .cache_rd_out(cache_rd_out),
        .cache_set_out(cache_set_out), .cache_entry_out(cache_entry_out),
        .cache_flush_out(cache_flush_out), .cache_data_in(cache_data_in),
        .cache_tag_in(cache_tag_in), .cache_valid_in(cache_valid_in),
        .cache_set_lru_in(cache_set_lru_in), .cache_set_valid_in(cache_set_valid_in)
    );
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic timeout(input string what);
        failures++;
        $display("wrong value at %0t: no answer for %s", $time, what);
        final_report();
    endtask
    // one idle cycle is left between strobes so no strobe is set twice in a step
    task automatic wr(input logic [2:0] sel, input logic [31:0] data);
        @(posedge clk_in);
        reg_wr_in    <= 1'b1;
        reg_sel_in   <= sel;
        reg_wdata_in <= data;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] sel, output logic [31:0] data);
        int n;
        @(posedge clk_in);
        reg_rd_in  <= 1'b1;
        reg_sel_in <= sel;
        @(posedge clk_in);
        reg_rd_in  <= 1'b0;
        for (n = 0; n < 3; n++)
        begin
            @(negedge clk_in);
            if (reg_rvalid_out === 1'b1)
                break;
        end
        if (n != 0)
            timeout("register read");
        data = reg_rdata_out;
    endtask
    task automatic wait_out(input bit flush);
        for (seen = 0; seen < 4; seen++)
        begin
            @(negedge clk_in);
            if ((flush ? cache_flush_out : cache_rd_out) === 1'b1)
                break;
        end
        if (seen == 4)
            timeout("cache array strobe");
    endtask
    function automatic logic [31:0] tcmd(input logic [19:0] lin, input logic v,
        input logic [1:0] d, input logic [1:0] u, input logic [1:0] w, input logic op);
        return {lin, v, d, u, w, 4'h0, op};
    endfunction
    function automatic logic [31:0] tdat(input logic [19:0] pa, input logic [1:0] at,
        input logic [2:0] lru, input logic f, input logic [1:0] way);
        return {pa, at, lru, 2'h0, f, way, 2'h0};
    endfunction
    // data register first: the command write is what launches the operation
    task automatic tw(input logic [31:0] data, input logic [31:0] cmd);
        wr(test_hooks_pkg::SEL_TLB_DATA, data);
        wr(test_hooks_pkg::SEL_TLB_CMD, cmd);
    endtask
    // bits 6:5 and 1:0 carry nothing after a hit, and only bit 4 is defined on a miss
    task automatic look(input logic [31:0] cmd, input logic [31:0] exp);
        logic [31:0] got;
        wr(test_hooks_pkg::SEL_TLB_CMD, cmd);
        rd(test_hooks_pkg::SEL_TLB_DATA, got);
        if (exp[4] === 1'b1)
            chk(got & 32'hFFFF_FF9C, exp, "tlb lookup hit");
        else
            chk({31'h0, got[4]}, 32'h0, "tlb lookup miss");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        failures           = 0;
        cmp_count          = 0;
        rst_in             = 1'b1;
        reg_wr_in          = 1'b0;
        reg_rd_in          = 1'b0;
        reg_sel_in         = 3'h0;
        reg_wdata_in       = 32'h0;
        cache_data_in      = 128'h0;
        cache_tag_in       = 21'h0;
        cache_valid_in     = 1'b0;
        cache_set_lru_in   = 3'h0;
        cache_set_valid_in = 4'h0;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        chk({29'h0, cache_rd_out, cache_flush_out, reg_rvalid_out}, 32'h0, "outputs at reset");
        rd(test_hooks_pkg::SEL_TLB_DATA, rdv);
        chk(rdv, test_hooks_pkg::REG_RESET, "data register reset");
        // cache line read into the read buffer, then drained word by word
        line_v = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
        cache_data_in      <= line_v;
        cache_tag_in       <= 21'h1A_5C3;
        cache_valid_in     <= 1'b1;
        cache_set_lru_in   <= 3'h5;
        cache_set_valid_in <= 4'hB;
        wr(test_hooks_pkg::SEL_CACHE_CTRL, {21'h0, 7'h55, 2'h3, test_hooks_pkg::CODE_READ});
        wait_out(1'b0);
        chk(32'(seen), 32'h0, "read strobe delay");
        chk({23'h0, cache_set_out, cache_entry_out}, {23'h0, 7'h55, 2'h3}, "read place");
        @(negedge clk_in);
        chk({30'h0, cache_rd_out, cache_flush_out}, 32'h0, "read strobe width");
        @(posedge clk_in);
        // array inputs change once sampled, so only the buffer can supply the line
        cache_data_in      <= ~line_v;
        cache_tag_in       <= ~21'h1A_5C3;
        cache_valid_in     <= 1'b0;
        cache_set_lru_in   <= 3'h2;
        cache_set_valid_in <= 4'h4;
        rd(test_hooks_pkg::SEL_CACHE_STAT, rdv);
        chk(rdv, {21'h1A_5C3, 1'b1, 3'h5, 4'hB, 3'h0}, "status after read");
        for (int n = 0; n < 4; n++)
        begin
            wr(test_hooks_pkg::SEL_CACHE_CTRL, {28'h0, 2'(n), test_hooks_pkg::CODE_BUFFER});
            rd(test_hooks_pkg::SEL_CACHE_DATA, rdv);
            chk(rdv, line_v[32*n +: 32], "buffer word");
        end
        rd(3'h1, rdv);
        chk(rdv, 32'h0, "unmapped select");
        wr(test_hooks_pkg::SEL_CACHE_CTRL, {21'h0, 7'h2A, 2'h1, test_hooks_pkg::CODE_READ});
        wait_out(1'b0);
        chk({23'h0, cache_set_out, cache_entry_out}, {23'h0, 7'h2A, 2'h1}, "read place");
        rd(test_hooks_pkg::SEL_CACHE_DATA, rdv);
        chk(rdv, 32'h0, "buffer read without code 00");
        wr(test_hooks_pkg::SEL_CACHE_CTRL, {28'h0, 2'h1, test_hooks_pkg::CODE_BUFFER});
        rd(test_hooks_pkg::SEL_CACHE_DATA, rdv);
        chk(rdv, ~line_v[63:32], "reloaded buffer word");
        // flush with every other control bit set
        wr(test_hooks_pkg::SEL_CACHE_CTRL, 32'hFFFF_FFFF);
        wait_out(1'b1);
        chk({31'h0, cache_rd_out}, 32'h0, "no array read on flush");
        chk(32'(seen), 32'h0, "flush strobe delay");
        @(negedge clk_in);
        chk({31'h0, cache_flush_out}, 32'h0, "flush strobe width");
        // tlb: entry a forced into way 2, lru field of the data register is junk
        look(tcmd(20'hABCD3, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1), 32'h0);
        tw(tdat(20'h12345, 2'h2, 3'h7, 1'b1, 2'h2),
           tcmd(20'hABCD3, 1'b1, 2'h2, 2'h1, 2'h2, 1'b0));
        look(tcmd(20'hABCD3, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1),
             tdat(20'h12345, 2'h2, 3'h4, 1'b1, 2'h2));
        for (int k = 0; k < 7; k++)
            look(tcmd(20'hABCD3, 1'b1, PAIR_CASES[k][6:5], PAIR_CASES[k][4:3],
                      PAIR_CASES[k][2:1], 1'b1),
                 PAIR_CASES[k][0] ? tdat(20'h12345, 2'h2, 3'h4, 1'b1, 2'h2) : 32'h0);
        look(tcmd(20'hABCD3, 1'b0, 2'h3, 2'h3, 2'h3, 1'b1), 32'h0);
        look(tcmd(20'hABCD4, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1), 32'h0);
        look(tcmd(20'hABCC3, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1), 32'h0);
        // entries b and c placed by the pseudo-lru pointer, way field ignored
        tw(tdat(20'hFEDCB, 2'h1, 3'h0, 1'b0, 2'h3),
           tcmd(20'h00013, 1'b1, 2'h1, 2'h2, 2'h1, 1'b0));
        look(tcmd(20'h00013, 1'b1, 2'h1, 2'h2, 2'h1, 1'b1),
             tdat(20'hFEDCB, 2'h1, 3'h7, 1'b1, 2'h0));
        look(tcmd(20'hABCD3, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1),
             tdat(20'h12345, 2'h2, 3'h7, 1'b1, 2'h2));
        tw(tdat(20'h5A5A5, 2'h3, 3'h0, 1'b0, 2'h0),
           tcmd(20'h00023, 1'b1, 2'h2, 2'h2, 2'h2, 1'b0));
        look(tcmd(20'h00023, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1),
             tdat(20'h5A5A5, 2'h3, 3'h5, 1'b1, 2'h1));
        look(tcmd(20'h00023, 1'b1, 2'h1, 2'h3, 2'h3, 1'b1), 32'h0);
        look(tcmd(20'hABCD3, 1'b1, 2'h3, 2'h3, 2'h3, 1'b1),
             tdat(20'h12345, 2'h2, 3'h5, 1'b1, 2'h2));
        final_report();
    end
endmodule // cache_tlb_test_hooks_tb_top
